// ---- rtl/asr_pkg.sv ----
package asr_pkg;
  // geometry of the static memory outside
  localparam int ADDR_W = 8;
  localparam int DATA_W = 4;
  localparam int WORDS  = 256;
  // pin timing in ns, clock period in ns
  localparam int CLK_NS   = 5;
  localparam int T_AS_NS  = 200;  // address setup before write strobe
  localparam int T_WRW_NS = 250;  // write strobe width
  localparam int T_WR_NS  = 50;   // write recovery
  localparam int T_ADA_NS = 450;  // access from address
  localparam int T_DOA_NS = 450;  // output valid from select
  localparam int T_ODS_NS = 200;  // inhibit setup on shared data lines
  // least times round up to whole cycles
  function automatic int cyc(input int ns);
    int c;
    c = (ns + CLK_NS - 1) / CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction
  localparam int AS_CYC  = cyc(T_AS_NS);
  localparam int WRW_CYC = cyc(T_WRW_NS);
  localparam int WR_CYC  = cyc(T_WR_NS);
  localparam int ACC_CYC = cyc(T_ADA_NS > T_DOA_NS ? T_ADA_NS : T_DOA_NS);
  localparam int ODS_CYC = cyc(T_ODS_NS);
  localparam int CNT_W   = 8;
  typedef enum logic [2:0] {
    ASR_IDLE, ASR_RD_WAIT, ASR_WR_SETUP, ASR_WR_PULSE, ASR_WR_RECOV
  } asr_state_e;
endpackage

// ---- rtl/asr_host.sv ----
`timescale 1ns/10ps
module asr_host
  import asr_pkg::*;
#(
  parameter bit SHARED_IO = 1'b0
)(
  input  wire logic                      clk,
  input  wire logic                      arst_n,
  input  wire logic                      reqValid,
  input  wire logic                      reqWrite,
  input  wire logic [asr_pkg::ADDR_W-1:0] reqAddr,
  input  wire logic [asr_pkg::DATA_W-1:0] reqData,
  output logic                           reqReady,
  output logic                           rspValid,
  output logic [asr_pkg::DATA_W-1:0]     rspData,
  output logic [asr_pkg::ADDR_W-1:0]     wordSelectLines,
  output logic [asr_pkg::DATA_W-1:0]     writeLines,
  input  wire logic [asr_pkg::DATA_W-1:0] readLines,
  output logic                           selectLow_n,
  output logic                           selectHigh,
  output logic                           outputInhibit,
  output logic                           writeStrobe_n
);
  import asr_pkg::*;

  asr_state_e              state_ff, nxt_state;
  logic [CNT_W-1:0]        cnt_ff, nxt_cnt;
  logic [ADDR_W-1:0]       addr_ff, nxt_addr;
  logic [DATA_W-1:0]       wdat_ff, nxt_wdat;
  logic [DATA_W-1:0]       rdat_ff, nxt_rdat;
  logic                    rvld_ff, nxt_rvld;
  logic                    rdy_ff, nxt_rdy;
  logic                    sel_ff, nxt_sel;
  // low-active select has its own flop so the pin is not an inverter
  logic                    sel_n_ff, nxt_sel_n;
  logic                    inh_ff, nxt_inh;
  logic                    wen_n_ff, nxt_wen_n;

  // sequencer: each pin phase is a timed state, no pin is pulsed shorter
  // than the device's least interval
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = (cnt_ff != '0) ? cnt_ff - 1'b1 : cnt_ff;
    nxt_addr  = addr_ff;
    nxt_wdat  = wdat_ff;
    nxt_rdat  = rdat_ff;
    nxt_rvld  = 1'b0;
    nxt_rdy   = rdy_ff;
    nxt_sel   = sel_ff;
    nxt_sel_n = sel_n_ff;
    nxt_inh   = inh_ff;
    nxt_wen_n = wen_n_ff;
    case (state_ff)
      ASR_IDLE: begin
        if (reqValid && rdy_ff) begin
          nxt_rdy  = 1'b0;
          nxt_addr = reqAddr;
          nxt_sel  = 1'b1;
          nxt_sel_n = 1'b0;
          if (reqWrite) begin
            nxt_wdat = reqData;
            // shared lines: inhibit first so read drivers are off
            // separate lines: inhibit may stay as it is
            nxt_inh  = SHARED_IO ? 1'b1 : inh_ff;
            nxt_cnt  = CNT_W'(SHARED_IO ? (AS_CYC > ODS_CYC ? AS_CYC
                                          : ODS_CYC) : AS_CYC);
            nxt_state = ASR_WR_SETUP;
          end else begin
            nxt_inh   = 1'b0;                        // enable drivers
            nxt_cnt   = CNT_W'(ACC_CYC);
            nxt_state = ASR_RD_WAIT;
          end
        end
      end
      ASR_RD_WAIT: begin
        // sample after full access time; pins held static meanwhile
        if (cnt_ff == '0) begin
          nxt_rdat  = readLines;
          nxt_rvld  = 1'b1;
          nxt_rdy   = 1'b1;
          nxt_state = ASR_IDLE;
          // keep select asserted: next address may follow at once
        end
      end
      ASR_WR_SETUP: begin
        if (cnt_ff == '0) begin
          nxt_wen_n = 1'b0;
          nxt_cnt   = CNT_W'(WRW_CYC);
          nxt_state = ASR_WR_PULSE;
        end
      end
      ASR_WR_PULSE: begin
        if (cnt_ff == '0) begin
          nxt_wen_n = 1'b1;
          nxt_cnt   = CNT_W'(WR_CYC);
          nxt_state = ASR_WR_RECOV;
        end
      end
      ASR_WR_RECOV: begin
        if (cnt_ff == '0) begin
          nxt_rdy   = 1'b1;
          nxt_state = ASR_IDLE;
        end
      end
      default: begin
        nxt_state = ASR_IDLE;
        nxt_rdy   = 1'b1;
        nxt_wen_n = 1'b1;
      end
    endcase
  end

  // registers only; all pins come straight from flops
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= ASR_IDLE;
      cnt_ff   <= '0;
      addr_ff  <= '0;
      wdat_ff  <= '0;
      rdat_ff  <= '0;
      rvld_ff  <= 1'b0;
      rdy_ff   <= 1'b1;
      sel_ff   <= 1'b0;
      sel_n_ff <= 1'b1;
      inh_ff   <= 1'b1;
      wen_n_ff <= 1'b1;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      addr_ff  <= nxt_addr;
      wdat_ff  <= nxt_wdat;
      rdat_ff  <= nxt_rdat;
      rvld_ff  <= nxt_rvld;
      rdy_ff   <= nxt_rdy;
      sel_ff   <= nxt_sel;
      sel_n_ff <= nxt_sel_n;
      inh_ff   <= nxt_inh;
      wen_n_ff <= nxt_wen_n;
    end
  end

  // pins and answers straight from their flops
  assign reqReady        = rdy_ff;
  assign rspValid        = rvld_ff;
  assign rspData         = rdat_ff;
  assign wordSelectLines = addr_ff;
  assign writeLines      = wdat_ff;
  assign selectLow_n     = sel_n_ff;
  assign selectHigh      = sel_ff;
  assign outputInhibit   = inh_ff;
  assign writeStrobe_n   = wen_n_ff;

  // helper: cycles the write strobe has been low
  logic [CNT_W-1:0] lowCnt;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) lowCnt <= '0;
    else if (!writeStrobe_n) lowCnt <= lowCnt + 1'b1;
    else lowCnt <= '0;
  end

  // pin-level guards on what this side drives
  a_write_selected: assert property (
    @(posedge clk) disable iff (!arst_n)
    !writeStrobe_n |-> (!selectLow_n && selectHigh))
    else $error("write strobe low while deselected");
  a_shared_inhibit: assert property (
    @(posedge clk) disable iff (!arst_n)
    (SHARED_IO && !writeStrobe_n) |-> outputInhibit)
    else $error("shared lines driven during write");
  a_inhibit_setup: assert property (
    @(posedge clk) disable iff (!arst_n)
    (SHARED_IO && $fell(writeStrobe_n)) |-> $past(outputInhibit, ODS_CYC))
    else $error("inhibit not set up before shared write");
  a_write_stable: assert property (
    @(posedge clk) disable iff (!arst_n)
    (!writeStrobe_n && !$past(writeStrobe_n)) |->
      ($stable(wordSelectLines) && $stable(writeLines)))
    else $error("address or data moved under write strobe");
  a_setup_span: assert property (
    @(posedge clk) disable iff (!arst_n)
    $fell(writeStrobe_n) |-> ($past(wordSelectLines, AS_CYC) ==
      wordSelectLines))
    else $error("address not set up before write strobe");
  a_strobe_width: assert property (
    @(posedge clk) disable iff (!arst_n)
    $rose(writeStrobe_n) |-> $past(lowCnt) >= CNT_W'(WRW_CYC))
    else $error("write strobe too short");
  a_recovery_gap: assert property (
    @(posedge clk) disable iff (!arst_n)
    $rose(writeStrobe_n) |-> (!reqReady) [*8])
    else $error("request accepted inside write recovery");
  a_read_drivers: assert property (
    @(posedge clk) disable iff (!arst_n)
    (state_ff == ASR_RD_WAIT) |-> (!outputInhibit && writeStrobe_n))
    else $error("read without output drivers enabled");
  a_access_select: assert property (
    @(posedge clk) disable iff (!arst_n)
    (state_ff == ASR_RD_WAIT) |-> (!selectLow_n && selectHigh))
    else $error("select dropped during access");
  a_read_hold: assert property (
    @(posedge clk) disable iff (!arst_n)
    (state_ff == ASR_RD_WAIT && $past(state_ff) == ASR_RD_WAIT) |->
      $stable(wordSelectLines))
    else $error("address moved during access");
  a_read_latency: assert property (
    @(posedge clk) disable iff (!arst_n)
    (reqValid && reqReady && !reqWrite) |-> ##92 rspValid)
    else $error("read answer not on time");
  a_addr_setup: assert property (
    @(posedge clk) disable iff (!arst_n)
    $fell(writeStrobe_n) |-> $past(state_ff) == ASR_WR_SETUP)
    else $error("write strobe without setup phase");

  // main scenarios: read, write, back to back, shared write, turnaround
  c_read:  cover property (@(posedge clk) disable iff (!arst_n) rspValid);
  c_write: cover property (@(posedge clk) disable iff (!arst_n)
    $rose(writeStrobe_n));
  c_b2b:   cover property (@(posedge clk) disable iff (!arst_n)
    rspValid && reqValid && reqReady);
  c_shared: cover property (@(posedge clk) disable iff (!arst_n)
    SHARED_IO && $fell(writeStrobe_n));
  c_rd_after_wr: cover property (@(posedge clk) disable iff (!arst_n)
    $rose(reqReady) && reqValid && !reqWrite);
endmodule

// ---- tb/asr_sram_model.sv ----
`timescale 1ns/10ps
module asr_sram_model
  import asr_pkg::*;
(
  input  wire logic [asr_pkg::ADDR_W-1:0] wordSelectLines,
  input  wire logic [asr_pkg::DATA_W-1:0] writeLines,
  output logic      [asr_pkg::DATA_W-1:0] readLines,
  input  wire logic                       selectLow_n,
  input  wire logic                       selectHigh,
  input  wire logic                       outputInhibit,
  input  wire logic                       writeStrobe_n
);
  import asr_pkg::*;
  logic [DATA_W-1:0] mem [WORDS]; // 256 four-bit words
  logic [DATA_W-1:0] lastOut = '0;
  logic              sel;
  assign sel = !selectLow_n && selectHigh;
  // purely level driven, no clock, no precharge
  always @* begin
    if (sel && !writeStrobe_n) mem[wordSelectLines] = writeLines;
    if (sel && !outputInhibit) begin // follows address at once
      readLines = mem[wordSelectLines];
      lastOut = readLines;
    end else begin
      readLines = ~lastOut; // deselected or inhibited: drive the inverse of the last output, no stale copy
    end
  end
endmodule

// ---- tb/asr_host_bench.sv ----
`timescale 1ns/10ps
module asr_host_bench;
  import asr_pkg::*;
  logic              clk = 0;
  logic              arst_n = 0;
  logic              reqValid = 0;
  logic              reqWrite = 0;
  logic [ADDR_W-1:0] reqAddr = '0;
  logic [DATA_W-1:0] reqData = '0;
  logic              reqReady, rspValid, selectLow_n, selectHigh;
  logic              outputInhibit, writeStrobe_n;
  logic [DATA_W-1:0] rspData, writeLines, readLines;
  logic [ADDR_W-1:0] wordSelectLines;
  logic              reqReadySh, rspValidSh, selLowSh_n, selHighSh;
  logic              inhibitSh, strobeSh_n;
  logic [DATA_W-1:0] rspDataSh, writeLinesSh, readLinesSh, expNow;
  logic [ADDR_W-1:0] addrSh;
  bit                lastWr;
  int                lastTake;
  logic [DATA_W-1:0] shadow [WORDS];
  logic [DATA_W-1:0] expQ [$];
  int                takeQ [$];
  logic [ADDR_W-1:0] used [$];
  int                err_count, comparisons, cyc;
  logic [31:0]       seed = 32'h5322fd70;
  asr_host uut (.clk(clk), .arst_n(arst_n), .reqValid(reqValid),
    .reqWrite(reqWrite), .reqAddr(reqAddr), .reqData(reqData),
    .reqReady(reqReady), .rspValid(rspValid), .rspData(rspData),
    .wordSelectLines(wordSelectLines), .writeLines(writeLines),
    .readLines(readLines), .selectLow_n(selectLow_n),
    .selectHigh(selectHigh), .outputInhibit(outputInhibit),
    .writeStrobe_n(writeStrobe_n));
  asr_sram_model mem0 (.wordSelectLines(wordSelectLines),
    .writeLines(writeLines), .readLines(readLines),
    .selectLow_n(selectLow_n), .selectHigh(selectHigh),
    .outputInhibit(outputInhibit), .writeStrobe_n(writeStrobe_n));
  // same requests into a shared-lines controller
  asr_host #(.SHARED_IO(1'b1)) uutShared (.clk(clk), .arst_n(arst_n),
    .reqValid(reqValid), .reqWrite(reqWrite), .reqAddr(reqAddr),
    .reqData(reqData), .reqReady(reqReadySh), .rspValid(rspValidSh),
    .rspData(rspDataSh), .wordSelectLines(addrSh),
    .writeLines(writeLinesSh), .readLines(readLinesSh),
    .selectLow_n(selLowSh_n), .selectHigh(selHighSh),
    .outputInhibit(inhibitSh), .writeStrobe_n(strobeSh_n));
  asr_sram_model memShared (.wordSelectLines(addrSh),
    .writeLines(writeLinesSh), .readLines(readLinesSh),
    .selectLow_n(selLowSh_n), .selectHigh(selHighSh),
    .outputInhibit(inhibitSh), .writeStrobe_n(strobeSh_n));
  initial begin
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %0t got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    if (err_count == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // wait for idle, then hold the request across its taking edge
  task automatic req(input logic wr, input logic [7:0] a,
                     input logic [3:0] d);
    int n;
    n = 0;
    while (reqReady !== 1'b1 || reqReadySh !== 1'b1) begin
      @(posedge clk);
      #1;
      n++;
      if (n > 300) begin
        err_count++;
        wrap_up();
      end
    end
    // a write holds the controller for setup, strobe and recovery
    if (lastWr) check(cyc - lastTake, AS_CYC + WRW_CYC + WR_CYC + 3);
    reqValid = 1;
    reqWrite = wr;
    reqAddr = a;
    reqData = d;
    @(posedge clk);
    lastWr = wr;
    lastTake = cyc + 1;
    if (wr) shadow[a] = d;
    else begin
      expQ.push_back(shadow[a]);
      takeQ.push_back(cyc + 1);
    end
    #1;
    reqValid = 0;
  endtask
  // result watcher: oldest note against each read answer
  always @(negedge clk) begin
    if (rspValid === 1'b1 && expQ.size() > 0) begin
      expNow = expQ.pop_front();
      check(rspData, expNow);
      check(rspDataSh, expNow);
      check(rspValidSh, 1'b1);
      check(cyc - takeQ.pop_front(), ACC_CYC + 1);
    end else if (rspValid === 1'b1 || rspValidSh === 1'b1) begin
      check(1, 0);
    end
  end
  initial begin
    repeat (16) @(posedge clk);
    #1;
    arst_n = 1;
    req(1, 8'h00, 4'ha);
    req(1, 8'hff, 4'h5);
    used.push_back(8'h00);
    used.push_back(8'hff);
    repeat (6) begin
      seed = lfsr(seed);
      req(1, seed[7:0], seed[11:8]);
      used.push_back(seed[7:0]);
    end
    for (int i = 0; i < used.size(); i++) req(0, used[i], 4'h0);
    req(1, 8'h00, 4'h3);
    req(0, 8'h00, 4'h0);
    req(0, 8'hff, 4'h0);
    repeat (200) @(posedge clk);
    if (expQ.size() != 0) err_count++;
    wrap_up();
  end
endmodule
